// ==== pkg/codec_seq_defines.vh ====
// constants of the codec power and path control block
// included by the sequencer design file; holds definitions only
`ifndef CODEC_SEQ_DEFINES_VH
`define CODEC_SEQ_DEFINES_VH

// clock rate of the control logic
`define CLK_MHZ 100

// register offsets (byte addresses of the plain register port)
`define REG_POWER 8'h00
`define REG_CLOCK 8'h01
`define REG_CONV_ROUTE 8'h02
`define REG_LINE_ROUTE 8'h03
`define REG_MODE 8'h04
`define REG_ATTEN 8'h05
`define REG_STATUS 8'h06

// power register fields
`define PWR_REF_VOLTAGE 0
`define PWR_CONVERTER 1
`define PWR_HP_LEFT 2
`define PWR_HP_RIGHT 3
`define PWR_MUTE_RELEASE 4
`define PWR_LINE_OUT 5
`define PWR_PLL 6
`define PWR_MONO_OUT 7

// clock register fields
`define CLK_MCLK_OUT_EN 0

// converter routing fields
`define CRT_L_HP 0
`define CRT_R_HP 1
`define CRT_L_LINE 2
`define CRT_R_LINE 3
`define CRT_L_MONO 4
`define CRT_R_MONO 5

// line input routing fields
`define LRT_L_HP 0
`define LRT_R_HP 1
`define LRT_L_LINE 2
`define LRT_R_LINE 3
`define LRT_L_MONO 4
`define LRT_R_MONO 5

// mode register fields
`define MODE_ATS 0

// status register fields
`define ST_PLL_LOCKED 0
`define ST_MCLK_PRESENT 1
`define ST_ATTEN_BUSY 2
`define ST_BIT_CLOCK 3
`define ST_FRAME_CLOCK 4

// reset values
`define POWER_RST 8'h00
`define CLOCK_RST 8'h00
`define ROUTE_RST 6'h00
`define MODE_RST 1'b0
`define ATTEN_RST 8'hFF

// digital-to-analog timing in sample periods, plus the attenuator step count
`define GROUP_DELAY_FS 22
`define ATT_SLOW_FS 11'd1061
`define ATT_FAST_FS 11'd265
`define ATT_STEPS 11'd255

// reference clock loss detection
`define MCLK_LOSS_NS 1000
`define MCLK_LOSS_CYC ((`MCLK_LOSS_NS * `CLK_MHZ + 999) / 1000)

// pll lock time
`define PLL_LOCK_US 200
`define PLL_LOCK_CYC (`PLL_LOCK_US * `CLK_MHZ)

`endif

// ==== design/pin_sync.v ====
// three-stage synchroniser for a group of pin inputs
// assumes each bit is an asynchronous level; output moves when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// pins and filtered levels
	input wire [WIDTH-1:0] pin,
	output reg [WIDTH-1:0] level_q
);

	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;
	integer i;

	always @(posedge clock) begin
		if (!rst_n) begin
			s1_q <= {WIDTH{1'b0}};
			s2_q <= {WIDTH{1'b0}};
			s3_q <= {WIDTH{1'b0}};
			level_q <= {WIDTH{1'b0}};
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s3_q[i];
				end
			end
		end
	end

endmodule

`default_nettype wire

// ==== design/sample_delay_line.v ====
// fixed delay of audio samples counted in frame periods
// assumes advance pulses once per frame; output is the sample taken DEPTH advances ago
`timescale 1ns/100ps
`default_nettype none

module sample_delay_line #(
	parameter WIDTH = 24,
	parameter DEPTH = 22
) (
	// clock and reset
	input wire clock,
	input wire clear,
	// sample stream
	input wire advance,
	input wire [WIDTH-1:0] sample_in,
	output reg [WIDTH-1:0] sample_out_q
);

	// a full DEPTH stages before the output flop, so a sample taken at advance k
	// leaves at advance k + DEPTH and not one advance early
	reg [WIDTH-1:0] stage_q [0:DEPTH-1];
	integer i;

	always @(posedge clock) begin
		if (clear) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				stage_q[i] <= {WIDTH{1'b0}};
			end
			sample_out_q <= {WIDTH{1'b0}};
		end else if (advance) begin
			stage_q[0] <= sample_in;
			for (i = 1; i < DEPTH; i = i + 1) begin
				stage_q[i] <= stage_q[i-1];
			end
			sample_out_q <= stage_q[DEPTH-1];
		end
	end

endmodule

`default_nettype wire

// ==== design/codec_path_sequencer.v ====
// power, clock and path control of a stereo converter with pll master clock
// assumes a same-clock host on the plain register port and async clock pins
//
// Function
// - pll runs only while a reference clock toggles on the master clock input.
// - after pll lock the device drives the master clock output pin.
// - analog output lags its digital sample by 22 sample periods.
// - transition select sets attenuator ramp time; default is 1061 sample periods.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "codec_seq_defines.vh"

module codec_path_sequencer #(
	parameter SAMPLE_W = 24,
	parameter LOCK_CYCLES = `PLL_LOCK_CYC,
	parameter GROUP_DELAY = `GROUP_DELAY_FS
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	// device pins
	input wire power_down_pin,
	input wire master_clock_input,
	input wire serial_bit_clock,
	input wire frame_clock,
	output reg master_clock_output,
	// audio samples from the serial receiver, same clock
	input wire [SAMPLE_W-1:0] sample_in,
	output reg [SAMPLE_W-1:0] sample_out,
	output reg sample_out_valid,
	// power controls
	output wire ref_voltage_enable,
	output wire pll_power_enable,
	output wire converter_power_enable,
	output wire hp_left_power,
	output wire hp_right_power,
	output wire hp_mute_release,
	output wire line_out_power,
	output wire mono_out_power,
	// converter routing
	output wire conv_left_to_hp_left,
	output wire conv_right_to_hp_right,
	output wire conv_left_to_line_left,
	output wire conv_right_to_line_right,
	output wire conv_left_to_mono,
	output wire conv_right_to_mono,
	// line input routing
	output wire line_in1_left_to_hp,
	output wire line_in1_right_to_hp,
	output wire line_in1_left_to_line,
	output wire line_in1_right_to_line,
	output wire line_in1_left_to_mono,
	output wire line_in1_right_to_mono,
	// status
	output wire pll_locked
);

	localparam LOSS_CYC = `MCLK_LOSS_CYC;

	wire [3:0] pins_s;
	wire pdn_s;
	wire mclk_s;
	wire bclk_s;
	wire fclk_s;
	wire clear;

	reg [7:0] power_q;
	reg [7:0] clock_ctl_q;
	reg [5:0] conv_route_q;
	reg [5:0] line_route_q;
	reg mode_q;
	reg [7:0] atten_target_q;

	reg mclk_prev_q;
	reg fclk_prev_q;
	reg [15:0] gap_q;
	reg mclk_present_q;
	reg [31:0] lock_cnt_q;
	reg locked_q;

	reg [7:0] level_q;
	reg [10:0] acc_q;
	reg [10:0] acc_sum;
	reg [10:0] period;
	reg frame_tick_q;
	reg frame_tick;

	wire [SAMPLE_W-1:0] delayed;
	wire [9:0] gain;
	wire signed [SAMPLE_W+9:0] product;
	reg [7:0] read_value;

	pin_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pin({frame_clock, serial_bit_clock, master_clock_input, power_down_pin}),
		.level_q(pins_s)
	);

	assign pdn_s = pins_s[0];
	assign mclk_s = pins_s[1];
	assign bclk_s = pins_s[2];
	assign fclk_s = pins_s[3];

	// power-down pin low holds all control state at its reset value
	assign clear = !rst_n || !pdn_s;

	assign ref_voltage_enable = power_q[`PWR_REF_VOLTAGE];
	assign converter_power_enable = power_q[`PWR_CONVERTER];
	assign hp_left_power = power_q[`PWR_HP_LEFT];
	assign hp_right_power = power_q[`PWR_HP_RIGHT];
	assign hp_mute_release = power_q[`PWR_MUTE_RELEASE];
	assign line_out_power = power_q[`PWR_LINE_OUT];
	assign pll_power_enable = power_q[`PWR_PLL];
	assign mono_out_power = power_q[`PWR_MONO_OUT];
	assign conv_left_to_hp_left = conv_route_q[`CRT_L_HP];
	assign conv_right_to_hp_right = conv_route_q[`CRT_R_HP];
	assign conv_left_to_line_left = conv_route_q[`CRT_L_LINE];
	assign conv_right_to_line_right = conv_route_q[`CRT_R_LINE];
	assign conv_left_to_mono = conv_route_q[`CRT_L_MONO];
	assign conv_right_to_mono = conv_route_q[`CRT_R_MONO];
	assign line_in1_left_to_hp = line_route_q[`LRT_L_HP];
	assign line_in1_right_to_hp = line_route_q[`LRT_R_HP];
	assign line_in1_left_to_line = line_route_q[`LRT_L_LINE];
	assign line_in1_right_to_line = line_route_q[`LRT_R_LINE];
	assign line_in1_left_to_mono = line_route_q[`LRT_L_MONO];
	assign line_in1_right_to_mono = line_route_q[`LRT_R_MONO];
	assign pll_locked = locked_q;

	// ordering of writes is left to the host; the block stores what it is given
	always @(posedge clock) begin
		if (clear) begin
			power_q <= `POWER_RST;
			clock_ctl_q <= `CLOCK_RST;
			conv_route_q <= `ROUTE_RST;
			line_route_q <= `ROUTE_RST;
			mode_q <= `MODE_RST;
			atten_target_q <= `ATTEN_RST;
		end else if (reg_write) begin
			case (reg_addr)
				`REG_POWER: power_q <= reg_wdata;
				`REG_CLOCK: clock_ctl_q <= {7'h00, reg_wdata[`CLK_MCLK_OUT_EN]};
				`REG_CONV_ROUTE: conv_route_q <= reg_wdata[5:0];
				`REG_LINE_ROUTE: line_route_q <= reg_wdata[5:0];
				`REG_MODE: mode_q <= reg_wdata[`MODE_ATS];
				`REG_ATTEN: atten_target_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	always @* begin
		case (reg_addr)
			`REG_POWER: read_value = power_q;
			`REG_CLOCK: read_value = clock_ctl_q;
			`REG_CONV_ROUTE: read_value = {2'b00, conv_route_q};
			`REG_LINE_ROUTE: read_value = {2'b00, line_route_q};
			`REG_MODE: read_value = {7'h00, mode_q};
			`REG_ATTEN: read_value = atten_target_q;
			`REG_STATUS: read_value = {3'b000, fclk_s, bclk_s, (level_q != atten_target_q),
				mclk_present_q, locked_q};
			default: read_value = 8'h00;
		endcase
	end

	// read data stand for exactly the cycle after the strobe
	always @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= read_value;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// reference clock presence: any edge within the loss window
	always @(posedge clock) begin
		if (clear) begin
			mclk_prev_q <= 1'b0;
			gap_q <= 16'h0000;
			mclk_present_q <= 1'b0;
		end else begin
			mclk_prev_q <= mclk_s;
			if (mclk_s != mclk_prev_q) begin
				gap_q <= 16'h0000;
				mclk_present_q <= 1'b1;
			end else if (gap_q < LOSS_CYC[15:0]) begin
				gap_q <= gap_q + 16'h0001;
			end else begin
				mclk_present_q <= 1'b0;
			end
		end
	end

	// pll lock timer; losing the reference or pll power drops lock at once
	always @(posedge clock) begin
		if (clear || !pll_power_enable || !mclk_present_q) begin
			lock_cnt_q <= 32'h00000000;
			locked_q <= 1'b0;
		end else if (lock_cnt_q < LOCK_CYCLES[31:0]) begin
			lock_cnt_q <= lock_cnt_q + 32'h00000001;
		end else begin
			locked_q <= 1'b1;
		end
	end

	// master clock out follows the reference only after lock
	always @(posedge clock) begin
		if (clear) begin
			master_clock_output <= 1'b0;
		end else begin
			master_clock_output <= locked_q && clock_ctl_q[`CLK_MCLK_OUT_EN] && mclk_s;
		end
	end

	// frame tick; frame clock is ignored while the converter is off, as it may stop
	always @(posedge clock) begin
		if (clear) begin
			fclk_prev_q <= 1'b0;
			frame_tick_q <= 1'b0;
		end else begin
			fclk_prev_q <= fclk_s;
			frame_tick_q <= frame_tick;
		end
	end

	always @* begin
		frame_tick = fclk_s && !fclk_prev_q && converter_power_enable;
	end

	sample_delay_line #(
		.WIDTH(SAMPLE_W),
		.DEPTH(GROUP_DELAY)
	) u_delay (
		.clock(clock),
		.clear(clear),
		.advance(frame_tick),
		.sample_in(sample_in),
		.sample_out_q(delayed)
	);

	// ramp spreads 255 steps evenly over the selected number of frames
	always @* begin
		period = mode_q ? `ATT_FAST_FS : `ATT_SLOW_FS;
		acc_sum = acc_q + `ATT_STEPS;
	end

	always @(posedge clock) begin
		if (clear) begin
			level_q <= `ATTEN_RST;
			acc_q <= 11'h000;
		end else if (level_q == atten_target_q) begin
			acc_q <= 11'h000;
		end else if (frame_tick) begin
			if (acc_sum >= period) begin
				acc_q <= acc_sum - period;
				if (level_q < atten_target_q) begin
					level_q <= level_q + 8'h01;
				end else begin
					level_q <= level_q - 8'h01;
				end
			end else begin
				acc_q <= acc_sum;
			end
		end
	end

	// level zero is a full mute, others scale by (level + 1) / 256
	assign gain = (level_q == 8'h00) ? 10'h000 : ({2'b00, level_q} + 10'h001);
	assign product = $signed(delayed) * $signed(gain);

	// one output sample per frame, one cycle after the delay line moves
	always @(posedge clock) begin
		if (clear) begin
			sample_out <= {SAMPLE_W{1'b0}};
			sample_out_valid <= 1'b0;
		end else begin
			sample_out_valid <= frame_tick_q;
			if (frame_tick_q) begin
				sample_out <= product[SAMPLE_W+7:8];
			end
		end
	end

endmodule

`default_nettype wire

// ==== sim/codec_seq_checker_assertions.sv ====
// port assertions of the codec path sequencer
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module codec_seq_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	// pins and controls
	input wire logic power_down_pin,
	input wire logic master_clock_output,
	input wire logic sample_out_valid,
	input wire logic ref_voltage_enable,
	input wire logic converter_power_enable,
	input wire logic line_out_power,
	input wire logic pll_power_enable,
	input wire logic pll_locked
);
	wire logic [3:0] pw_bits = {reg_wdata[6:5], reg_wdata[1:0]};
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_mclk_needs_lock: assert property (!pll_locked && !$past(pll_locked) |-> !master_clock_output)
		else $error("clock out without lock");
	a_lock_needs_pll: assert property ($rose(pll_locked) |-> pll_power_enable && $past(pll_power_enable, 8))
		else $error("lock without pll power");
	a_lock_drops: assert property (!pll_power_enable ##1 !pll_power_enable |-> !pll_locked)
		else $error("lock held without pll power");
	a_valid_single: assert property (sample_out_valid |=> !sample_out_valid[*4])
		else $error("sample valid too long");
	a_valid_conv_on: assert property (sample_out_valid |-> $past(converter_power_enable, 2))
		else $error("sample with converter off");
	a_read_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_power_write: assert property (power_down_pin[*8] ##0 (reg_write && reg_addr == 8'h00) |=>
		{pll_power_enable, line_out_power, converter_power_enable, ref_voltage_enable} == $past(pw_bits))
		else $error("power write lost");
	a_power_readback: assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata[6:5] == {pll_power_enable, line_out_power})
		else $error("power readback wrong");
	a_pin_clears: assert property (!power_down_pin[*8] |-> !ref_voltage_enable && !pll_power_enable && !pll_locked)
		else $error("power-down pin did not clear");
endmodule
bind codec_path_sequencer codec_seq_checker codec_seq_checker_inst (.clock(clock), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .power_down_pin(power_down_pin), .master_clock_output(master_clock_output),
	.sample_out_valid(sample_out_valid), .ref_voltage_enable(ref_voltage_enable),
	.converter_power_enable(converter_power_enable), .line_out_power(line_out_power),
	.pll_power_enable(pll_power_enable), .pll_locked(pll_locked));
`default_nettype wire

// ==== sim/far_clock_source.sv ====
// far-end clock source: reference clock and audio clocks
// assumes bit and frame clocks are divided from the master clock output
`timescale 1ns/100ps
`default_nettype none
module far_clock_source (
	// controls
	input wire logic ref_on,
	input wire logic converter_power_enable,
	input wire logic master_clock_output,
	// clock pins
	output logic master_clock_input,
	output logic serial_bit_clock,
	output logic frame_clock
);
	logic [1:0] div_q = 2'h0;
	initial begin
		master_clock_input = 1'b0;
		serial_bit_clock = 1'b0;
		frame_clock = 1'b0;
	end
	// 10 MHz reference, held low while stopped
	always #50 master_clock_input = ref_on ? !master_clock_input : 1'b0;
	// audio clocks stand still low while the converter is off
	always @(master_clock_output) begin
		if (!converter_power_enable) begin
			div_q = 2'h0;
		end else if (master_clock_output) begin
			div_q = div_q + 2'h1;
		end
		serial_bit_clock = div_q[0];
		frame_clock = div_q[1];
	end
endmodule
`default_nettype wire

// ==== sim/codec_path_sequencer_tb.sv ====
// self-checking bench of the codec path sequencer
// assumes the far clock model and the bound port checker
`timescale 1ns/100ps
`default_nettype none
module codec_path_sequencer_tb;
	localparam int SETTLE = 200; // scaled stand-in for the 2 ms wait
	logic clock = 0, rst_n = 0, power_down_pin = 0, ref_on = 0;
	logic reg_write = 0, reg_read = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [23:0] sample_in = 24'h5A3C1E;
	logic [23:0] v22 = 24'h0, v23 = 24'h0;
	logic [7:0] pbits [3] = '{8'h1C, 8'h20, 8'h80};
	wire logic [7:0] reg_rdata, pwr;
	wire logic [5:0] crt, lrt;
	wire logic [23:0] sample_out;
	wire logic master_clock_input, serial_bit_clock, frame_clock;
	wire logic master_clock_output, sample_out_valid, pll_locked;
	int fail_count = 0, checks_done = 0, vcount = 0, mco_rises = 0, cycles = 0;

	codec_path_sequencer #(.LOCK_CYCLES(50)) codec_path_sequencer_inst (.clock(clock),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .power_down_pin(power_down_pin),
		.master_clock_input(master_clock_input), .serial_bit_clock(serial_bit_clock),
		.frame_clock(frame_clock), .master_clock_output(master_clock_output),
		.sample_in(sample_in), .sample_out(sample_out), .sample_out_valid(sample_out_valid),
		.ref_voltage_enable(pwr[0]), .converter_power_enable(pwr[1]), .hp_left_power(pwr[2]),
		.hp_right_power(pwr[3]), .hp_mute_release(pwr[4]), .line_out_power(pwr[5]),
		.pll_power_enable(pwr[6]), .mono_out_power(pwr[7]),
		.conv_left_to_hp_left(crt[0]), .conv_right_to_hp_right(crt[1]),
		.conv_left_to_line_left(crt[2]), .conv_right_to_line_right(crt[3]),
		.conv_left_to_mono(crt[4]), .conv_right_to_mono(crt[5]),
		.line_in1_left_to_hp(lrt[0]), .line_in1_right_to_hp(lrt[1]),
		.line_in1_left_to_line(lrt[2]), .line_in1_right_to_line(lrt[3]),
		.line_in1_left_to_mono(lrt[4]), .line_in1_right_to_mono(lrt[5]),
		.pll_locked(pll_locked));
	far_clock_source far_clock_source_inst (.ref_on(ref_on), .converter_power_enable(pwr[1]),
		.master_clock_output(master_clock_output), .master_clock_input(master_clock_input),
		.serial_bit_clock(serial_bit_clock), .frame_clock(frame_clock));

	always #5 clock = !clock;
	always @(posedge master_clock_output) mco_rises++;
	always @(posedge clock) begin
		cycles++;
		if (sample_out_valid === 1'b1) begin
			vcount++;
			if (vcount == 22) v22 = sample_out;
			if (vcount == 23) v23 = sample_out;
		end
		if (cycles == 60000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	// idle cycle after each strobe keeps drivers single per step
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, mask, exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk("read data", 24'(exp), 24'(reg_rdata & mask));
		@(posedge clock);
	endtask
	task automatic until_lock(input logic want);
		int n;
		n = 0;
		while (pll_locked !== want && n < 400) begin
			@(posedge clock);
			n++;
		end
		chk("pll_locked", 24'(want), 24'(pll_locked));
	endtask
	// waits until k more output samples have been counted
	task automatic frames(input int k);
		int n0;
		int t;
		n0 = vcount;
		t = 0;
		while (vcount < n0 + k && t < 1000) begin
			@(posedge clock);
			t++;
		end
	endtask

	initial begin
		int n;
		logic [7:0] ra, base;
		logic [5:0] rv;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		wr(8'h00, 8'hFF);
		chk("power while pin low", 24'h0, 24'(pwr));
		power_down_pin <= 1'b1;
		repeat (6) @(posedge clock);
		rd(8'h05, 8'hFF, 8'hFF);
		rd(8'h07, 8'hFF, 8'h00);
		wr(8'h00, 8'h43);
		wr(8'h01, 8'h01);
		chk("power bits", 24'h43, 24'(pwr));
		ref_on <= 1'b1;
		until_lock(1'b1);
		rd(8'h06, 8'h03, 8'h03);
		n = mco_rises;
		repeat (100) @(posedge clock);
		n = mco_rises - n;
		chk("clock out running", 24'h1, 24'(n >= 9 && n <= 11));
		n = 0;
		while (vcount < 23 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		chk("sample before delay", 24'h0, v22);
		chk("sample after delay", sample_in, v23);
		ref_on <= 1'b0;
		until_lock(1'b0);
		ref_on <= 1'b1;
		until_lock(1'b1);
		for (int i = 0; i < 6; i++) begin
			ra = (i < 3) ? 8'h02 : 8'h03;
			base = (i < 3) ? 8'h43 : 8'h41;
			rv = 6'h03 << (2 * (i % 3));
			wr(8'h00, base);
			wr(ra, {2'h0, rv});
			chk("routing", 24'(rv), 24'((i < 3) ? crt : lrt));
			rd(ra, 8'hFF, {2'h0, rv});
			repeat (SETTLE) @(posedge clock);
			wr(8'h00, base | pbits[i % 3]);
			chk("path power", 24'(base | pbits[i % 3]), 24'(pwr));
			rd(8'h00, 8'hFF, base | pbits[i % 3]);
			repeat (SETTLE) @(posedge clock);
			wr(8'h00, base);
			wr(ra, 8'h00);
			chk("routing cleared", 24'h0, 24'({crt, lrt}));
		end
		wr(8'h04, 8'h01);
		rd(8'h04, 8'hFF, 8'h01);
		wr(8'h05, 8'h00);
		rd(8'h06, 8'h04, 8'h04);
		// fast ramp: one step needs two frames, so three frames finish it
		wr(8'h00, 8'h43);
		wr(8'h05, 8'hFE);
		frames(3);
		rd(8'h06, 8'h04, 8'h00);
		// slow ramp: one step needs five frames, so three leave it busy
		wr(8'h04, 8'h00);
		wr(8'h05, 8'hFD);
		frames(3);
		rd(8'h06, 8'h04, 8'h04);
		power_down_pin <= 1'b0;
		repeat (8) @(posedge clock);
		chk("power after pin low", 24'h0, 24'({pwr, pll_locked}));
		close_out();
	end
endmodule
`default_nettype wire
